// ---- hdl/bcr_pkg.sv ----
// Package of constants and types for the step-down converter control register bank.
package bcr_pkg;

    // ----------------------------------------------------------------
    // Register offsets and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_VOLTAGE_SELECT = 8'h30;
    localparam logic [7:0] ADDR_OPERATING_SCHEME = 8'h31;
    localparam logic [7:0] ADDR_RESERVED_STATUS = 8'h32;
    localparam logic [7:0] ADDR_ENABLE_STATUS = 8'h33;
    localparam int LEVEL_CODE_MSB = 5;
    localparam int BAND_BIT = 6;
    localparam int SCHEME_BIT = 0;
    localparam int ENABLE_BIT = 0;
    localparam int POWER_OK_BIT = 1;
    localparam int WRITE_EXACT_BIT = 2;

    // Writable masks; every other bit is read-only.
    localparam logic [7:0] MASK_VOLTAGE_SELECT = 8'h7f;
    localparam logic [7:0] MASK_OPERATING_SCHEME = 8'h01;
    localparam logic [7:0] MASK_ENABLE_STATUS = 8'h05;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SOFT_START_US = 80;
    localparam int SOFT_START_CYCLES = (SOFT_START_US * 1000) / CLK_PERIOD_NS;
    localparam int RAMP_W = 16;
    localparam logic [RAMP_W-1:0] RAMP_ONE = 16'h0001;

    // Target voltage in millivolts; zero marks an unavailable code.
    localparam int MV_W = 13;

    typedef enum logic [1:0]
    {
        BCR_OFF = 2'b00,
        BCR_RAMP = 2'b01,
        BCR_ON = 2'b10
    } bcr_state_t;

endpackage : bcr_pkg

// ---- hdl/bcr_level_rom.sv ----
// Level code to target millivolt lookup with a registered output.
`timescale 1ns/10ps
module bcr_level_rom
(
    input wire logic clk,
    input wire logic band,
    input wire logic [5:0] code,
    output logic [bcr_pkg::MV_W-1:0] millivolts
);
    import bcr_pkg::*;

    // ----------------------------------------------------------------
    // Table
    // ----------------------------------------------------------------
    // Band 1 is uniform 50 mV steps from 1250; band 0 has irregular steps so is listed.
    function automatic logic [MV_W-1:0] lookup(input logic b, input logic [5:0] c);
        logic [MV_W-1:0] r;
        r = 13'h0000;
        if (b)
        begin
            r = MV_W'(1250 + 50 * int'(c));
        end
        else
        begin
            case (c[5:4])
                2'b01: r = (c[3:0] < 4'h2) ? 13'h0000 :
                    MV_W'((c[3:0] < 4'h8) ? (1050 + 25 * int'(c[3:0])) : (1055 + 25 * int'(c[3:0])));
                2'b10: r = MV_W'((c[3:0] < 4'h5) ? (1455 + 25 * int'(c[3:0])) : (1460 + 25 * int'(c[3:0])));
                2'b11:
                begin
                    case (c[3:0])
                        4'h0: r = 13'h0744;
                        4'h1: r = 13'h0762;
                        4'he: r = 13'h0898;
                        4'hf: r = 13'h08c5;
                        default: r = MV_W'(1865 + 25 * int'(c[3:0]));
                    endcase
                end
                default: r = 13'h0000;
            endcase
        end
        return r;
    endfunction : lookup

    always_ff @(posedge clk)
    begin
        millivolts <= lookup(band, code);
    end

endmodule : bcr_level_rom

// ---- hdl/bcr_regs.sv ----
// Register bank and enable logic for the third step-down converter.
// Contract
// RQ1: 30h holds six-bit level code in bits 5:0 and band bit 6.
// RQ2: Level code and band map to target voltage by table lookup.
// RQ3: Listed bits are read-only with implementation-defined values.
// RQ4: 31h bit 0 selects automatic or forced fixed-frequency switching.
// RQ5: Converter three runs only while its pin is high and enable bit set.
// RQ6: Converters one and two on when master low or hold high, and bit set.
// RQ7: 33h bit 1 reads power-OK, clearing when output drops below threshold.
// RQ8: Host writes 33h bit 2 only with its default value.
// RQ9: Enabling ramps output over an 80 microsecond monotonic soft start.
// RQ10: At power-up each converter regulates to its default voltage.
// RQ11: Host changes voltages only through level code and band writes.
// RQ12: Writes to read-only bits are ignored; other fields still update.
`timescale 1ns/10ps
module bcr_regs
#(
    parameter logic [5:0] DEFAULT_LEVEL_CODE = 6'h02,
    parameter logic DEFAULT_BAND = 1'b1,
    parameter logic DEFAULT_ENABLE = 1'b1,
    parameter logic DEFAULT_WRITE_EXACT = 1'b0,
    parameter logic [7:0] READ_ONLY_VALUE = 8'h00,
    parameter logic CONV1_ENABLE_BIT = 1'b1,
    parameter logic CONV2_ENABLE_BIT = 1'b1,
    parameter int SOFT_START_LEN = bcr_pkg::SOFT_START_CYCLES
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic master_enable_n,
    input wire logic power_hold_input,
    input wire logic converter3_enable_pin,
    input wire logic output_good,
    output logic third_converter_run,
    output logic third_converter_ramping,
    output logic [bcr_pkg::RAMP_W-1:0] soft_start_step,
    output logic forced_fixed_frequency,
    output logic [bcr_pkg::MV_W-1:0] target_millivolts,
    output logic first_converter_run,
    output logic second_converter_run
);
    import bcr_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0] mst_sync;
        logic [1:0] hold_sync;
        logic [1:0] pin_sync;
        logic [1:0] good_sync;
        logic [5:0] level_code;
        logic band;
        logic scheme;
        logic enable;
        logic write_exact;
        logic power_ok;
        logic [7:0] rdata;
        bcr_state_t state;
        logic [RAMP_W-1:0] ramp;
        logic run1;
        logic run2;
        logic run3;
        logic ramping;
    } bcr_regs_t;

    bcr_regs_t cur;
    bcr_regs_t next_cur;
    logic run_request;

    // Merge only the writable bits; read-only bits are never stored.
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
        return (old & ~m) | (wd & m);
    endfunction : merge

    // ----------------------------------------------------------------
    // Lookup
    // ----------------------------------------------------------------
    bcr_level_rom u_rom
    (
        .clk(clk),
        .band(cur.band),
        .code(cur.level_code),
        .millivolts(target_millivolts) // see RQ2
    );

    assign run_request = cur.pin_sync[1] & cur.enable; // see RQ5

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    // Pins pass two flops; only the second stage feeds logic.
    always_comb
    begin
        logic [7:0] v;
        v = 8'h00;
        next_cur = cur;
        next_cur.mst_sync = {cur.mst_sync[0], master_enable_n};
        next_cur.hold_sync = {cur.hold_sync[0], power_hold_input};
        next_cur.pin_sync = {cur.pin_sync[0], converter3_enable_pin};
        next_cur.good_sync = {cur.good_sync[0], output_good};
        // Power-OK follows the comparator while the converter is fully up.
        next_cur.power_ok = cur.good_sync[1] && (cur.state == BCR_ON); // see RQ7
        next_cur.run1 = (~cur.mst_sync[1] | cur.hold_sync[1]) & CONV1_ENABLE_BIT; // see RQ6
        next_cur.run2 = (~cur.mst_sync[1] | cur.hold_sync[1]) & CONV2_ENABLE_BIT; // see RQ6
        if (reg_write)
        begin
            case (reg_addr)
                ADDR_VOLTAGE_SELECT:
                begin
                    v = merge({1'b0, cur.band, cur.level_code}, reg_wdata, MASK_VOLTAGE_SELECT); // see RQ12
                    next_cur.level_code = v[LEVEL_CODE_MSB:0]; // see RQ1
                    next_cur.band = v[BAND_BIT]; // see RQ1
                end
                ADDR_OPERATING_SCHEME: next_cur.scheme = reg_wdata[SCHEME_BIT]; // see RQ4
                ADDR_ENABLE_STATUS:
                begin
                    next_cur.enable = reg_wdata[ENABLE_BIT]; // see RQ5
                    next_cur.write_exact = reg_wdata[WRITE_EXACT_BIT]; // see RQ8
                end
                default: ;
            endcase
        end
        // Read data is registered; read-only bits other than power-OK show the fixed value.
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_VOLTAGE_SELECT: next_cur.rdata = merge(READ_ONLY_VALUE, {1'b0, cur.band, cur.level_code},
                    MASK_VOLTAGE_SELECT); // see RQ3
                ADDR_OPERATING_SCHEME: next_cur.rdata = merge(READ_ONLY_VALUE, {7'h00, cur.scheme},
                    MASK_OPERATING_SCHEME); // see RQ3
                ADDR_RESERVED_STATUS: next_cur.rdata = READ_ONLY_VALUE; // see RQ3
                ADDR_ENABLE_STATUS:
                begin
                    v = merge(READ_ONLY_VALUE, {5'h00, cur.write_exact, 1'b0, cur.enable}, MASK_ENABLE_STATUS);
                    v[POWER_OK_BIT] = cur.power_ok; // see RQ7
                    next_cur.rdata = v;
                end
                default: next_cur.rdata = 8'h00;
            endcase
        end
        // Soft start counts a fixed ramp; dropping the request stops at once.
        case (cur.state)
            BCR_OFF:
            begin
                next_cur.ramp = '0;
                if (run_request)
                begin
                    next_cur.state = BCR_RAMP; // see RQ9
                end
            end
            BCR_RAMP:
            begin
                if (!run_request)
                begin
                    next_cur.state = BCR_OFF;
                end
                else if (cur.ramp == RAMP_W'(SOFT_START_LEN - 1))
                begin
                    next_cur.state = BCR_ON;
                end
                else
                begin
                    next_cur.ramp = cur.ramp + RAMP_ONE; // see RQ9
                end
            end
            BCR_ON:
            begin
                if (!run_request)
                begin
                    next_cur.state = BCR_OFF;
                end
            end
            default: next_cur.state = BCR_OFF;
        endcase
        // Run flags are decoded ahead of the flop so the outputs carry no decode logic.
        next_cur.run3 = (next_cur.state != BCR_OFF); // see RQ5
        next_cur.ramping = (next_cur.state == BCR_RAMP); // see RQ9
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Reset loads the factory default level so power-up regulates there.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cur <= '0;
            cur.mst_sync <= 2'b11;
            cur.level_code <= DEFAULT_LEVEL_CODE; // see RQ10
            cur.band <= DEFAULT_BAND; // see RQ10
            cur.enable <= DEFAULT_ENABLE;
            cur.write_exact <= DEFAULT_WRITE_EXACT;
            cur.state <= BCR_OFF;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign reg_rdata = cur.rdata;
    assign third_converter_run = cur.run3;
    assign third_converter_ramping = cur.ramping;
    assign soft_start_step = cur.ramp;
    assign forced_fixed_frequency = cur.scheme;
    assign first_converter_run = cur.run1;
    assign second_converter_run = cur.run2;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_level_write;
        @(posedge clk) disable iff (sys_rst)
        reg_write && reg_addr == ADDR_VOLTAGE_SELECT |=> cur.level_code == $past(reg_wdata[5:0]);
    endproperty
    a_level_write: assert property (p_level_write) else $error("Level code not stored."); // see RQ1

    property p_band_write;
        @(posedge clk) disable iff (sys_rst)
        reg_write && reg_addr == ADDR_VOLTAGE_SELECT |=> cur.band == $past(reg_wdata[6]);
    endproperty
    a_band_write: assert property (p_band_write) else $error("Band bit not stored."); // see RQ1

    property p_band1_lookup;
        @(posedge clk) disable iff (sys_rst)
        cur.band && $stable(cur.level_code) && $stable(cur.band) |=>
            target_millivolts == MV_W'(1250 + 50 * int'($past(cur.level_code)));
    endproperty
    a_band1_lookup: assert property (p_band1_lookup) else $error("Band one lookup wrong."); // see RQ2

    property p_reserved_read;
        @(posedge clk) disable iff (sys_rst)
        reg_read && reg_addr == ADDR_RESERVED_STATUS |=> reg_rdata == READ_ONLY_VALUE;
    endproperty
    a_reserved_read: assert property (p_reserved_read) else $error("Reserved register changed."); // see RQ3

    property p_scheme;
        @(posedge clk) disable iff (sys_rst)
        reg_write && reg_addr == ADDR_OPERATING_SCHEME |=> forced_fixed_frequency == $past(reg_wdata[0]);
    endproperty
    a_scheme: assert property (p_scheme) else $error("Scheme bit not applied."); // see RQ4

    property p_disable;
        @(posedge clk) disable iff (sys_rst)
        !cur.enable ##1 !cur.enable |-> !third_converter_run;
    endproperty
    a_disable: assert property (p_disable) else $error("Converter runs while disabled."); // see RQ5

    property p_first_on;
        @(posedge clk) disable iff (sys_rst)
        (!cur.mst_sync[1] || cur.hold_sync[1]) && CONV1_ENABLE_BIT |=> first_converter_run;
    endproperty
    a_first_on: assert property (p_first_on) else $error("First converter not enabled."); // see RQ6

    property p_power_ok;
        @(posedge clk) disable iff (sys_rst)
        !cur.good_sync[1] |=> !cur.power_ok;
    endproperty
    a_power_ok: assert property (p_power_ok) else $error("Power-OK held while output low."); // see RQ7

    property p_ramp_len;
        @(posedge clk) disable iff (sys_rst)
        cur.state == BCR_RAMP && cur.ramp == RAMP_W'(SOFT_START_LEN - 1) && run_request |=> cur.state == BCR_ON;
    endproperty
    a_ramp_len: assert property (p_ramp_len) else $error("Soft start did not end on time."); // see RQ9

    property p_ro_bit;
        @(posedge clk) disable iff (sys_rst)
        reg_read && reg_addr == ADDR_VOLTAGE_SELECT |=> reg_rdata[7] == READ_ONLY_VALUE[7];
    endproperty
    a_ro_bit: assert property (p_ro_bit) else $error("Read-only bit was written."); // see RQ12

endmodule : bcr_regs

// ---- sim/bcr_host_model.sv ----
// Host-side model that issues register accesses to the converter register bank.
`timescale 1ns/10ps
module bcr_host_model
(
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    import bcr_pkg::*;

    // The bus idles with both strobes low.
    initial
    begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    // One byte write; the write-exact bit always goes out at its default of zero.
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_wdata <= (addr == ADDR_ENABLE_STATUS) ? (data & 8'hfb) : data;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_addr <= ~addr; // Released lines do not keep the old value.
        reg_wdata <= ~data;
    endtask : wr

    // One byte read; the answer is taken just after the second edge that follows the request.
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        reg_addr <= addr;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        reg_addr <= ~addr;
        @(posedge clk);
        #1;
        data = reg_rdata;
    endtask : rd

endmodule : bcr_host_model

// ---- sim/tb_top.sv ----
// Self-checking testbench for the converter register bank.
`timescale 1ns/10ps
module tb_top;
    import bcr_pkg::*;

    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_write, reg_read;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic master_enable_n = 1'b1;
    logic power_hold_input = 1'b0;
    logic converter3_enable_pin = 1'b0;
    logic output_good = 1'b0;
    logic run3, ramp3, ffm, run1, run2;
    logic [RAMP_W-1:0] step;
    logic [MV_W-1:0] mv;
    int miscompares = 0;
    int check_count = 0;
    // Band, code and expected millivolts for the lookup corners.
    logic [19:0] lut [0:6] = '{{7'h00, 13'h0000}, {7'h11, 13'h0000}, {7'h12, 13'h044c}, {7'h20, 13'h05af},
        {7'h3f, 13'h08c5}, {7'h40, 13'h04e2}, {7'h7f, 13'h1130}};

    // Short ramp keeps the soft start inside a few cycles.
    bcr_regs #(.SOFT_START_LEN(8)) uut (.clk(clk), .sys_rst(sys_rst), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .master_enable_n(master_enable_n), .power_hold_input(power_hold_input),
        .converter3_enable_pin(converter3_enable_pin), .output_good(output_good),
        .third_converter_run(run3), .third_converter_ramping(ramp3), .soft_start_step(step),
        .forced_fixed_frequency(ffm), .target_millivolts(mv), .first_converter_run(run1),
        .second_converter_run(run2));

    bcr_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    // Free-running 125 MHz clock.
    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic rdchk(input string name, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(addr, d);
        chk(name, {8'h00, exp}, {8'h00, d});
    endtask : rdchk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        rdchk("reg30", ADDR_VOLTAGE_SELECT, 8'h42);
        rdchk("reg31", ADDR_OPERATING_SCHEME, 8'h00);
        rdchk("reg32", ADDR_RESERVED_STATUS, 8'h00);
        rdchk("reg33", ADDR_ENABLE_STATUS, 8'h01);
        chk("target_millivolts", 16'h0546, {3'b000, mv});
        $display("test reset done");
    endtask : test_reset

    task automatic test_fields();
        host.wr(ADDR_VOLTAGE_SELECT, 8'hff);
        rdchk("reg30", ADDR_VOLTAGE_SELECT, 8'h7f);
        host.wr(ADDR_OPERATING_SCHEME, 8'hff);
        rdchk("reg31", ADDR_OPERATING_SCHEME, 8'h01);
        chk("forced_fixed_frequency", 16'h1, {15'h0, ffm});
        host.wr(ADDR_OPERATING_SCHEME, 8'h00);
        cyc(2);
        chk("forced_fixed_frequency", 16'h0, {15'h0, ffm});
        host.wr(ADDR_RESERVED_STATUS, 8'hff);
        rdchk("reg32", ADDR_RESERVED_STATUS, 8'h00);
        host.wr(ADDR_ENABLE_STATUS, 8'hff);
        rdchk("reg33", ADDR_ENABLE_STATUS, 8'h01);
        for (int i = 0; i < 7; i++)
        begin
            host.wr(ADDR_VOLTAGE_SELECT, {1'b0, lut[i][19:13]});
            cyc(3);
            chk("target_millivolts", {3'b000, lut[i][12:0]}, {3'b000, mv});
        end
        $display("test fields done");
    endtask : test_fields

    task automatic test_enable();
        logic [RAMP_W-1:0] prev;
        int n;
        host.wr(ADDR_ENABLE_STATUS, 8'h00);
        @(posedge clk) converter3_enable_pin <= 1'b1;
        cyc(5);
        chk("run3", 16'h0, {15'h0, run3});
        host.wr(ADDR_ENABLE_STATUS, 8'h01);
        cyc(1);
        chk("ramp3", 16'h1, {15'h0, ramp3 & run3});
        prev = step;
        n = 0;
        while (ramp3 === 1'b1 && n < 40)
        begin
            cyc(1);
            chk("ramp step", 16'h1, {15'h0, step >= prev});
            prev = step;
            n++;
        end
        if (n == 40)
        begin
            miscompares++;
            complete_run();
        end
        chk("ramp length", 16'h1, {15'h0, n == 8});
        rdchk("reg33", ADDR_ENABLE_STATUS, 8'h01);
        @(posedge clk) output_good <= 1'b1;
        cyc(5);
        rdchk("reg33", ADDR_ENABLE_STATUS, 8'h03);
        @(posedge clk) output_good <= 1'b0;
        cyc(5);
        rdchk("reg33", ADDR_ENABLE_STATUS, 8'h01);
        @(posedge clk) converter3_enable_pin <= 1'b0;
        cyc(5);
        chk("run3", 16'h0, {15'h0, run3});
        $display("test enable done");
    endtask : test_enable

    task automatic test_conv12();
        logic [2:0] tab [0:3] = '{3'b100, 3'b001, 3'b111, 3'b100};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            master_enable_n <= tab[i][2];
            power_hold_input <= tab[i][1];
            cyc(5);
            chk("run1 run2", {14'h0, {2{tab[i][0]}}}, {14'h0, run1, run2});
        end
        $display("test conv12 done");
    endtask : test_conv12

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        cyc(2);
        test_reset();
        test_fields();
        test_enable();
        test_conv12();
        complete_run();
    end

    // A hang counts as a mismatch and ends the run.
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        complete_run();
    end

endmodule : tb_top
